// [design/sdc_crc_check.sv]
// serial crc check over each received frame
`timescale 1ns/1ns
module sdc_crc_check
    import sdc_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // link
    sdc_link_if.crc link
);
    logic [7:0] crc_r;

    // command bits and crc shift in together; a zero remainder means intact
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            crc_r <= CRC_SEED;
        end else if (link.frame_start) begin
            crc_r <= CRC_SEED;
        end else if (link.bit_valid) begin
            crc_r <= crc8_step(crc_r, link.bit_val);
        end
    end

    assign link.crc_ok = (crc_r == CRC_GOOD);

endmodule // sdc_crc_check

// [design/sdc_link_if.sv]
// internal link between the spi shifter, crc checker and command control
`timescale 1ns/1ns
interface sdc_link_if;
    logic frame_start;
    logic frame_end;
    logic active;
    logic bit_valid;
    logic bit_val;
    logic [5:0] bit_count;
    logic [31:0] rx_word;
    logic miso;
    logic tx_load;
    logic [31:0] tx_word;
    logic crc_ok;

    modport shifter (
        output frame_start, frame_end, active, bit_valid, bit_val, bit_count, rx_word, miso,
        input tx_load, tx_word
    );
    modport ctrl (
        input frame_start, frame_end, active, bit_count, rx_word, miso, crc_ok,
        output tx_load, tx_word
    );
    modport crc (
        input frame_start, bit_valid, bit_val,
        output crc_ok
    );
endinterface

// [design/sdc_pkg.sv]
// constants, types and frame helpers for the sensor data command decoder
// Notes on behaviour
// - a data request is answered in the very next spi frame
// - the reported sample is taken when slave select falls for the answer frame
// - command bits 3:1 pick the source; the answer echoes them under a set bit 31
// - two basic status bits sit at frame bits 27:26
// - twelve sensor value bits follow, msb first
// - four optional extra resolution bits follow; zero when the option is off
// - two detailed status bits sit at frame bits 9:8
// - every frame ends with an 8-bit crc in bits 7:0
// - nibbles 0000 0010 0100 0110 1010 1110 are reserved yet still answered
// - the echo nibble of a reserved answer is undefined
// - bits 27:8 of a reserved answer are undefined
// - crc covers all 32 bits msb first, poly 0x2f, seed all ones
// - a crc mismatch drops the command and the error frame answers
package sdc_pkg;

    localparam logic [5:0] FRAME_BITS = 6'h20;
    localparam logic [5:0] COUNT_MAX = 6'h3f;
    localparam int CMD_MSB = 31;
    localparam int CMD_LSB = 28;
    localparam int HEAD_MSB = 31;
    localparam int HEAD_LSB = 8;
    localparam int CRC_MSB = 7;
    localparam int HEAD_BITS = 24;
    localparam int CRC_BITS = 8;
    localparam logic [7:0] CRC_SEED = 8'hff;
    localparam logic [7:0] CRC_POLY = 8'h2f;
    localparam logic [7:0] CRC_GOOD = 8'h00;
    localparam logic [0:0] ANSWER_MARK = 1'h1;
    localparam logic [3:0] NO_EXTRA_RES = 4'h0;
    localparam logic [19:0] RSV_FILL = 20'h00000;
    // arbitrary payload of the error answer
    localparam logic [23:0] ERR_HEAD = 24'h0f0000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_FRAME = 2'b10
    } frame_state_e;

    typedef enum logic [2:0] {
        REP_ERR = 3'b001,
        REP_DATA = 3'b010,
        REP_RSV = 3'b100
    } reply_kind_e;

    function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic din);
        logic [7:0] nxt;
        nxt = {crc[6:0], din};
        if (crc[7]) begin
            nxt = nxt ^ CRC_POLY;
        end
        return nxt;
    endfunction

    // augmented form: message then eight zeros leaves the crc in the register
    function automatic logic [7:0] crc8_word(input logic [23:0] head);
        logic [7:0] crc;
        crc = CRC_SEED;
        for (int i = HEAD_BITS - 1; i >= 0; i--) begin
            crc = crc8_step(crc, head[i]);
        end
        for (int i = 0; i < CRC_BITS; i++) begin
            crc = crc8_step(crc, 1'b0);
        end
        return crc;
    endfunction

    function automatic logic [31:0] seal_frame(input logic [23:0] head);
        return {head, crc8_word(head)};
    endfunction

    function automatic logic is_reserved(input logic [3:0] nib);
        return (nib == 4'h0) || (nib == 4'h2) || (nib == 4'h4) ||
            (nib == 4'h6) || (nib == 4'ha) || (nib == 4'he);
    endfunction

endpackage

// [design/sdc_spi_shifter.sv]
// spi pin synchronisers and 32-bit shift engine, mode 0
`timescale 1ns/1ns
module sdc_spi_shifter
    import sdc_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // spi pins
    input wire logic i_sclk,
    input wire logic i_ss_b,
    input wire logic i_mosi,
    // link
    sdc_link_if.shifter link
);
    logic sclk_s1_r, sclk_s2_r, sclk_s3_r;
    logic ss_b_s1_r, ss_b_s2_r, ss_b_s3_r;
    logic mosi_s1_r, mosi_s2_r;
    logic [31:0] rx_r;
    logic [31:0] tx_r;
    logic [5:0] count_r;
    logic sclk_rise;
    logic sclk_fall;

    // the third stage only delays the clean second stage for edge finding
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sclk_s1_r <= 1'b0;
            sclk_s2_r <= 1'b0;
            sclk_s3_r <= 1'b0;
            ss_b_s1_r <= 1'b1;
            ss_b_s2_r <= 1'b1;
            ss_b_s3_r <= 1'b1;
            mosi_s1_r <= 1'b0;
            mosi_s2_r <= 1'b0;
        end else begin
            sclk_s1_r <= i_sclk;
            sclk_s2_r <= sclk_s1_r;
            sclk_s3_r <= sclk_s2_r;
            ss_b_s1_r <= i_ss_b;
            ss_b_s2_r <= ss_b_s1_r;
            ss_b_s3_r <= ss_b_s2_r;
            mosi_s1_r <= i_mosi;
            mosi_s2_r <= mosi_s1_r;
        end
    end

    assign sclk_rise = sclk_s2_r & ~sclk_s3_r;
    assign sclk_fall = ~sclk_s2_r & sclk_s3_r;
    assign link.active = ~ss_b_s2_r;
    assign link.frame_start = ss_b_s3_r & ~ss_b_s2_r;
    assign link.frame_end = ~ss_b_s3_r & ss_b_s2_r;
    assign link.bit_valid = sclk_rise & ~ss_b_s2_r;
    assign link.bit_val = mosi_s2_r;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rx_r <= '0;
            count_r <= '0;
        end else if (link.frame_start) begin
            count_r <= '0;
        end else if (link.bit_valid) begin
            rx_r <= {rx_r[30:0], mosi_s2_r};
            if (count_r != COUNT_MAX) begin
                count_r <= count_r + 6'h01;
            end
        end
    end

    // msb first; bit 31 is on the pin before the first rising edge
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tx_r <= '0;
        end else if (link.tx_load) begin
            tx_r <= link.tx_word;
        end else if (sclk_fall && link.active) begin
            tx_r <= {tx_r[30:0], 1'b0};
        end
    end

    assign link.rx_word = rx_r;
    assign link.bit_count = count_r;
    assign link.miso = tx_r[CMD_MSB];

endmodule // sdc_spi_shifter

// [design/spi_sensor_data_cmd_decoder.sv]
// sensor data and reserved command decoder behind a 32-bit spi slave
`timescale 1ns/1ns
module spi_sensor_data_cmd_decoder
    import sdc_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // spi pins
    input wire logic i_sclk,
    input wire logic i_ss_b,
    input wire logic i_mosi,
    output logic o_miso,
    output logic o_miso_oe,
    // sensor side
    input wire logic [11:0] i_sensor_value_field,
    input wire logic [3:0] i_extra_resolution,
    input wire logic i_extra_res_en,
    input wire logic [1:0] i_basic_status_field,
    input wire logic [1:0] i_detailed_status_field,
    // command results
    output logic [2:0] o_sensor_source_select,
    output logic o_data_request,
    output logic o_reserved_cmd,
    output logic o_crc_error,
    output logic o_length_error,
    output logic o_busy
);
    sdc_link_if link();

    frame_state_e state_r;
    frame_state_e state_nxt;
    reply_kind_e reply_r;
    logic [2:0] source_r;
    logic [3:0] echo_r;
    logic miso_oe_r;
    logic data_req_r;
    logic rsv_cmd_r;
    logic crc_err_r;
    logic len_err_r;
    logic busy_r;
    logic [3:0] nib;
    logic len_ok;
    logic frame_good;
    logic [3:0] extra_bits;
    logic [23:0] head;
    logic take_data;
    logic take_rsv;
    logic take_crc_bad;
    logic take_len_bad;

    sdc_spi_shifter u_shifter (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_sclk(i_sclk),
        .i_ss_b(i_ss_b),
        .i_mosi(i_mosi),
        .link(link)
    );

    sdc_crc_check u_crc (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .link(link)
    );

    // only the top nibble classifies; fixed bits are covered by the crc alone
    assign nib = link.rx_word[CMD_MSB:CMD_LSB];
    assign len_ok = (link.bit_count == FRAME_BITS);
    assign frame_good = len_ok && link.crc_ok;

    // frame tracking
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (link.frame_start) begin
                    state_nxt = ST_FRAME;
                end
            end
            ST_FRAME: begin
                if (link.frame_end) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // decide the next frame's answer when the command frame closes
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            reply_r <= REP_ERR;
            source_r <= '0;
            echo_r <= '0;
        end else if (link.frame_end) begin
            echo_r <= nib;
            if (!frame_good) begin
                reply_r <= REP_ERR;
            end else if (nib[0]) begin
                reply_r <= REP_DATA;
                source_r <= nib[3:1];
            end else if (is_reserved(nib)) begin
                reply_r <= REP_RSV;
            end else begin
                // register access commands are not served by this block
                reply_r <= REP_ERR;
            end
        end
    end

    // answer assembly at slave select fall, so the sample is that instant's
    assign extra_bits = i_extra_res_en ? i_extra_resolution : NO_EXTRA_RES;

    always_comb begin
        head = ERR_HEAD;
        case (reply_r)
            REP_DATA: begin
                head = {ANSWER_MARK, source_r, i_basic_status_field,
                    i_sensor_value_field, extra_bits,
                    i_detailed_status_field};
            end
            REP_RSV: begin
                // echo and data are undefined; plain echo and zero fill keep it simple
                head = {echo_r, RSV_FILL};
            end
            default: begin
                head = ERR_HEAD;
            end
        endcase
    end

    assign link.tx_load = link.frame_start;
    assign link.tx_word = seal_frame(head);

    // at most one verdict per closed frame, none for a register command; length outranks crc so at most one pulse fires
    assign take_data = link.frame_end && frame_good && nib[0];
    assign take_rsv = link.frame_end && frame_good && is_reserved(nib);
    assign take_crc_bad = link.frame_end && len_ok && !link.crc_ok;
    assign take_len_bad = link.frame_end && !len_ok;

    // status pulses, each a single cycle
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            data_req_r <= 1'b0;
        end else begin
            data_req_r <= take_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rsv_cmd_r <= 1'b0;
        end else begin
            rsv_cmd_r <= take_rsv;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            crc_err_r <= 1'b0;
        end else begin
            crc_err_r <= take_crc_bad;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            len_err_r <= 1'b0;
        end else begin
            len_err_r <= take_len_bad;
        end
    end

    // pin enable follows the synchronised select, so it trails the pin by three clocks
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            miso_oe_r <= 1'b0;
        end else begin
            miso_oe_r <= link.active;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= (state_nxt == ST_FRAME);
        end
    end

    assign o_miso = link.miso;
    assign o_miso_oe = miso_oe_r;
    assign o_sensor_source_select = source_r;
    assign o_data_request = data_req_r;
    assign o_reserved_cmd = rsv_cmd_r;
    assign o_crc_error = crc_err_r;
    assign o_length_error = len_err_r;
    assign o_busy = busy_r;

    // checks
    data_next_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (link.frame_end && frame_good && nib[0]) |=>
            (reply_r == REP_DATA) && (source_r == $past(nib[3:1])))
        else $error("data request not scheduled for the next frame");

    sample_at_fall_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (link.frame_start && reply_r == REP_DATA) |->
            (link.tx_word[25:14] == i_sensor_value_field))
        else $error("reported sample differs from value at select fall");

    echo_head_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (link.frame_start && reply_r == REP_DATA) |->
            (link.tx_word[31] == ANSWER_MARK) && (link.tx_word[30:28] == o_sensor_source_select))
        else $error("answer echo wrong");

    basic_status_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (link.frame_start && reply_r == REP_DATA) |->
            (link.tx_word[27:26] == i_basic_status_field))
        else $error("basic status misplaced");

    extra_res_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (link.frame_start && reply_r == REP_DATA && !i_extra_res_en) |->
            (link.tx_word[13:10] == NO_EXTRA_RES))
        else $error("extra resolution bits not clear");

    detail_status_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (link.frame_start && reply_r == REP_DATA) |->
            (link.tx_word[9:8] == i_detailed_status_field))
        else $error("detailed status misplaced");

    crc_field_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        link.frame_start |=> (link.miso == $past(link.tx_word[31]))
            ##0 (crc8_word($past(link.tx_word[31:8])) == $past(link.tx_word[7:0])))
        else $error("answer crc wrong or frame not loaded");

    crc_reject_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (link.frame_end && len_ok && !link.crc_ok) |=>
            (reply_r == REP_ERR) && o_crc_error && !o_data_request)
        else $error("bad crc command was not rejected");

    reserved_ans_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (link.frame_end && frame_good && is_reserved(nib)) |=>
            (reply_r == REP_RSV) && o_reserved_cmd)
        else $error("reserved command not answered");

    extra_on_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (link.frame_start && reply_r == REP_DATA && i_extra_res_en) |->
            (link.tx_word[13:10] == i_extra_resolution))
        else $error("extra resolution bits not passed on");

    rsv_answer_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (link.frame_start && reply_r == REP_RSV) |->
            (link.tx_word[31:8] == {echo_r, RSV_FILL}))
        else $error("reserved answer content wrong");

    err_answer_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (link.frame_start && reply_r == REP_ERR) |->
            (link.tx_word[31:8] == ERR_HEAD))
        else $error("error answer content wrong");

    len_reject_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (link.frame_end && !len_ok) |=>
            (reply_r == REP_ERR) && o_length_error && !o_data_request && !o_reserved_cmd)
        else $error("short or long frame was not rejected");

    reg_cmd_err_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (link.frame_end && frame_good && !nib[0] && !is_reserved(nib)) |=>
            (reply_r == REP_ERR) && !o_data_request && !o_reserved_cmd)
        else $error("register command not answered with the error frame");

    pulse_onehot_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        link.frame_end |=>
            $onehot0({o_data_request, o_reserved_cmd, o_crc_error, o_length_error}))
        else $error("more than one verdict pulse");

    quiet_pulse_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !link.frame_end |=>
            !(o_data_request || o_reserved_cmd || o_crc_error || o_length_error))
        else $error("verdict pulse without a closed frame");

    source_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !(link.frame_end && frame_good && nib[0]) |=>
            $stable(o_sensor_source_select))
        else $error("source select moved without a data request");

    pin_enable_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        link.frame_start |=>
            o_miso_oe && o_busy)
        else $error("pin not driven once select is seen");

    pin_release_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        link.frame_end |=>
            !o_miso_oe && !o_busy)
        else $error("pin still driven after select rose");

endmodule // spi_sensor_data_cmd_decoder

// [verif/spi_host_model.sv]
// spi host controller model, mode 0, for the sensor data command decoder
`timescale 1ns/1ns
module spi_host_model (
    // clock
    input wire logic i_clk,
    // spi pins
    input wire logic i_miso,
    output logic o_sclk,
    output logic o_ss_b,
    output logic o_mosi,
    // captured answer
    output logic o_rx_done,
    output logic [31:0] o_rx_word
);
    initial begin
        o_sclk = 1'b0;
        o_ss_b = 1'b1;
        o_mosi = 1'b1;
        o_rx_done = 1'b0;
        o_rx_word = 32'h0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask

    // nbits other than 32 only provokes a length fault; no answer is reported then
    task automatic xfer(input logic [32:0] tx, input int nbits);
        logic [31:0] rx;
        rx = 32'h0;
        tick(1);
        o_ss_b = 1'b0;
        o_mosi = tx[nbits-1]; // msb first
        tick(6);
        for (int i = nbits - 1; i >= 0; i--) begin
            o_sclk = 1'b1;
            rx = {rx[30:0], i_miso};
            tick(4);
            o_sclk = 1'b0;
            if (i > 0) begin
                o_mosi = tx[i-1];
            end
            tick(6);
        end
        o_ss_b = 1'b1;
        // released line shows the inverse so a stale bit never looks valid
        o_mosi = ~o_mosi;
        tick(1);
        // non-blocking so a monitor on the same edge sees exactly one pulse
        o_rx_done <= (nbits == 32);
        o_rx_word <= rx;
        tick(1);
        o_rx_done <= 1'b0;
        tick(5);
    endtask
endmodule // spi_host_model

// [verif/tb_spi_sensor_data_cmd_decoder.sv]
// self-checking bench for the sensor data command decoder
`timescale 1ns/1ns
module tb_spi_sensor_data_cmd_decoder;
    import sdc_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic sclk, ss_b, mosi, miso, miso_oe;
    logic [11:0] val = 12'h0;
    logic [3:0] ext = 4'h0;
    logic ext_en = 1'b0;
    logic [1:0] bas = 2'h0;
    logic [1:0] det = 2'h0;
    logic [2:0] sel;
    logic dreq, rsv, crce, lene, busy, rx_done;
    logic [31:0] rx_word;
    logic [31:0] seed = 32'hb19010cc;
    logic [31:0] exp_word[$];
    logic [7:0] exp_ev[$];
    int errors = 0;
    int n_tests = 0;
    logic [1:0] pend_kind = 2'd0;
    logic [3:0] pend_nib = 4'h0;
    logic [2:0] cur_src = 3'h0;

    always #50 i_clk = ~i_clk;

    spi_sensor_data_cmd_decoder u_dut (
        .i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_sclk(sclk), .i_ss_b(ss_b), .i_mosi(mosi), .o_miso(miso), .o_miso_oe(miso_oe),
        .i_sensor_value_field(val), .i_extra_resolution(ext), .i_extra_res_en(ext_en),
        .i_basic_status_field(bas), .i_detailed_status_field(det),
        .o_sensor_source_select(sel), .o_data_request(dreq), .o_reserved_cmd(rsv),
        .o_crc_error(crce), .o_length_error(lene), .o_busy(busy)
    );

    spi_host_model u_host (
        .i_clk(i_clk), .i_miso(miso), .o_sclk(sclk), .o_ss_b(ss_b), .o_mosi(mosi),
        .o_rx_done(rx_done), .o_rx_word(rx_word)
    );

    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    function automatic logic [7:0] crc_ref(input logic [31:0] w);
        logic [7:0] c;
        c = 8'hff;
        for (int i = 31; i >= 0; i--) begin
            c = {c[6:0], w[i]} ^ (c[7] ? 8'h2f : 8'h00);
        end
        return c;
    endfunction

    function automatic logic [31:0] seal(input logic [23:0] h);
        return {h, crc_ref({h, 8'h00})};
    endfunction

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_flags(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic new_sensor();
        logic [31:0] r;
        r = rnd();
        {bas, val, ext, ext_en, det} = r[20:0];
    endtask

    task automatic end_of_test();
        $display("comparisons %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic do_reset(input int n);
        @(negedge i_clk);
        i_rst_b = 1'b0;
        repeat (n) @(negedge i_clk);
        i_rst_b = 1'b1;
        pend_kind = 2'd0;
        cur_src = 3'h0;
        repeat (4) @(negedge i_clk);
        cmp_flags({5'h0, sel}, 8'h00);
    endtask

    // each frame notes the pulse of this command and, when 32 bits long, the answer owed by the previous one
    task automatic frame(input logic [32:0] tx, input int nbits);
        logic [31:0] cmd;
        logic [23:0] h;
        logic [3:0] ev;
        cmd = tx[31:0];
        ev = 4'h0;
        // fresh sample just before select falls, so an early capture would show
        new_sensor();
        case (pend_kind)
            2'd1: h = {1'b1, cur_src, bas, val, ext_en ? ext : 4'h0, det};
            2'd2: h = {pend_nib, RSV_FILL};
            default: h = ERR_HEAD;
        endcase
        if (nbits == 32) begin
            exp_word.push_back(seal(h));
        end
        pend_kind = 2'd0;
        if (nbits != 32) begin
            ev = 4'b1000;
        end else if (crc_ref(cmd) !== 8'h00) begin
            ev = 4'b0100;
        end else if (cmd[28]) begin
            ev = 4'b0001;
            pend_kind = 2'd1;
            cur_src = cmd[31:29];
        end else if (cmd[31:28] inside {4'h0, 4'h2, 4'h4, 4'h6, 4'ha, 4'he}) begin
            ev = 4'b0010;
            pend_kind = 2'd2;
            pend_nib = cmd[31:28];
        end
        if (ev != 4'h0) begin
            exp_ev.push_back({1'b0, ev, cur_src});
        end
        fork
            u_host.xfer(tx, nbits);
            begin
                // later sensor changes must not reach the answer in flight
                repeat (20) @(negedge i_clk);
                cmp_flags({6'h0, busy, miso_oe}, 8'h03);
                new_sensor();
            end
        join
        cmp_flags({6'h0, busy, miso_oe}, 8'h00);
    endtask

    always @(negedge i_clk) begin
        if ({lene, crce, rsv, dreq} !== 4'h0) begin
            cmp_flags({1'b0, lene, crce, rsv, dreq, sel},
                exp_ev.size() ? exp_ev.pop_front() : 8'hff);
        end
        if (rx_done !== 1'b0) begin
            cmp_word(rx_word, exp_word.size() ? exp_word.pop_front() :
                ~rx_word);
        end
    end

    initial begin
        repeat (60000) @(posedge i_clk);
        errors++;
        end_of_test();
    end

    initial begin
        logic [31:0] r;
        do_reset(8);
        cmp_word({24'h0, crc_ref(32'h8022c100)}, 32'h000000bd);
        // every nibble once, back to back; even ones carry junk below the nibble
        for (int n = 0; n < 16; n++) begin
            r = rnd();
            frame({1'b0, seal({n[3:0], n[0] ? 20'h0 : r[19:0]})}, 32);
        end
        frame({1'b0, seal(24'hd00000)}, 31);
        frame({seal(24'hd00000), 1'b1}, 33);
        // a full-length frame follows the 33-bit fault and the crc fault so each error answer is compared
        frame({1'b0, seal(24'h700000) ^ 32'h1}, 32);
        frame({1'b0, seal(24'h900000)}, 32);
        do_reset(2);
        frame({1'b0, seal(24'hb00000)}, 32);
        frame({1'b0, seal(24'h200000)}, 32);
        for (int i = 0; i < 100 && exp_ev.size() + exp_word.size() > 0; i++) begin
            @(negedge i_clk);
        end
        if (exp_ev.size() + exp_word.size() > 0) begin
            errors++;
        end
        end_of_test();
    end
endmodule // tb_spi_sensor_data_cmd_decoder
